// *** dv/cfv_settings_mem.sv ***
// partner: stored settings memory with one-cycle read latency
`timescale 1ns/100ps
`default_nettype none
module cfv_settings_mem #(
  parameter int AW = 5
) (
  // read port
  input  wire logic          clock,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [15:0]   rd_data
);
  logic [15:0] mem_ff [2**AW];
  // data follows the address by one cycle
  always_ff @(posedge clock) begin
    rd_data <= mem_ff[rd_addr];
  end
endmodule // cfv_settings_mem
`default_nettype wire

// *** dv/cfv_validator_sva.sv ***
// checker: port-level assertions of the settings validator
`timescale 1ns/100ps
`default_nettype none
module cfv_validator_sva
  import cfv_pkg::*;
#(
  parameter int NCNT      = 2,
  parameter int LOG_DEPTH = LOG_DEPTH_DEF
) (
  // all ports of the validator
  input wire logic                              clock,
  input wire logic                              resetn,
  input wire logic [$clog2(NCNT*CNT_STRIDE)-1:0] set_rd_addr,
  input wire logic [WORD_W-1:0]                 set_rd_data,
  input wire logic                              io_write_command,
  input wire logic                              restart_req,
  input wire logic                              fetch_next_fault_strobe,
  input wire cfv_io_s                           io_word_area,
  input wire logic                              counting_enable,
  input wire logic                              validating
);
  // cycles of one undisturbed pass: load plus fifteen check steps per counter
  localparam int PASS_LEN = NCNT * CNT_STRIDE + 1 + NCNT * (int'(K_OVL) + 1);
  logic [7:0] pass_cnt_ff;
  logic [7:0] nxt_pass_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // cycles since the pass began, saturating
  always_comb begin
    nxt_pass_cnt = pass_cnt_ff;
    if (io_write_command || restart_req) begin
      nxt_pass_cnt = 8'h00;
    end else if (pass_cnt_ff != 8'hff) begin
      nxt_pass_cnt = pass_cnt_ff + 8'h01;
    end
  end
  // pass cycle counter register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pass_cnt_ff <= 8'h00;
    end else begin
      pass_cnt_ff <= nxt_pass_cnt;
    end
  end
  // a start from either command source
  sequence s_start;
    io_write_command || restart_req;
  endsequence
  // no command in this cycle
  sequence s_quiet;
    !io_write_command && !restart_req;
  endsequence
  // address steps from zero to one, then to two
  sequence s_walk;
    set_rd_addr == 1 && $past(set_rd_addr) == 0 ##1 set_rd_addr == 2;
  endsequence
  chk_start_clears: assert property (s_start |=> validating && !counting_enable && io_word_area == '0)
    else $error("start did not clear");
  chk_load_walk: assert property (s_start ##1 s_quiet [*2] |-> s_walk)
    else $error("load address order wrong");
  chk_pass_ends: assert property (validating |-> pass_cnt_ff < PASS_LEN)
    else $error("pass too long");
  chk_pass_length: assert property ($fell(validating) |-> pass_cnt_ff == PASS_LEN)
    else $error("pass length wrong");
  chk_halt_fault: assert property (io_word_area.status[STATUS_ANY_BIT] |-> !counting_enable)
    else $error("counting with fault");
  chk_run_holds: assert property (counting_enable && !(io_write_command || restart_req)
                                  |=> counting_enable)
    else $error("run dropped");
  chk_pass_run: assert property ($fell(validating) && !io_word_area.status[STATUS_ANY_BIT]
                                 |-> counting_enable)
    else $error("clean pass did not run");
  chk_flag_set: assert property (io_word_area.fault.code1 != '0 |-> io_word_area.status[STATUS_ANY_BIT])
    else $error("fault without flag");
  chk_flag_holds: assert property (io_word_area.status[0] && !(io_write_command || restart_req)
                                   |=> $stable(io_word_area.status))
    else $error("flag changed");
  chk_status_zero: assert property (io_word_area.status[15:1] == '0)
    else $error("status spare bits set");
  chk_empty_fetch: assert property ($rose(fetch_next_fault_strobe) && !validating
                                    && !io_word_area.status[0] |=> io_word_area.fault == '0)
    else $error("empty fetch not zero");
endmodule // cfv_validator_sva
bind cfv_validator cfv_validator_sva #(.NCNT(NCNT), .LOG_DEPTH(LOG_DEPTH)) u_sva (
  .clock(clock), .resetn(resetn), .set_rd_addr(set_rd_addr), .set_rd_data(set_rd_data),
  .io_write_command(io_write_command), .restart_req(restart_req),
  .fetch_next_fault_strobe(fetch_next_fault_strobe), .io_word_area(io_word_area),
  .counting_enable(counting_enable), .validating(validating));
`default_nettype wire

// *** dv/tb_cfv_validator.sv ***
// testbench: validation passes, fault log and fetch of the settings validator
`timescale 1ns/100ps
`default_nettype none
module tb_cfv_validator
  import cfv_pkg::*;
;
  logic        clock, resetn, io_write_command, restart_req, fetch_next_fault_strobe;
  logic [4:0]  set_rd_addr;
  logic [15:0] set_rd_data;
  cfv_io_s     io_word_area;
  logic        counting_enable, validating;
  int          fails, check_count;
  // clean counter block and expected log of the faulty set
  localparam logic [15:0] CLEAN [16] = '{16'h0, 16'h0, 16'h9999, 16'h0010, 16'h0100, 16'h0200, 16'h0300,
    16'h0400, 16'h0010, 16'h0020, 16'h0030, 16'h0040, 16'h0, 16'h0, 16'h0, 16'h0};
  localparam logic [31:0] EXP [8] = '{32'h0310_0012, 32'h0311_0003, 32'h0320_0101, 32'h0330_0102,
    32'h0320_0008, 32'h0330_0204, 32'h0331_0201, 32'h0335_0026};
  cfv_validator #(.NCNT(2), .LOG_DEPTH(30)) DUT (.clock(clock), .resetn(resetn),
    .set_rd_addr(set_rd_addr), .set_rd_data(set_rd_data), .io_write_command(io_write_command),
    .restart_req(restart_req), .fetch_next_fault_strobe(fetch_next_fault_strobe),
    .io_word_area(io_word_area), .counting_enable(counting_enable), .validating(validating));
  cfv_settings_mem #(.AW(5)) u_mem (.clock(clock), .rd_addr(set_rd_addr), .rd_data(set_rd_data));
  // clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(string n, logic [47:0] e, logic [47:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic put_clean();
    for (int i = 0; i < 32; i++) u_mem.mem_ff[i] = CLEAN[i%16];
    u_mem.mem_ff[16] = 16'h0001;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    @(posedge clock);
    while (validating !== 1'b0 && n < 500) begin
      @(posedge clock);
      n++;
    end
    repeat (2) @(posedge clock);
    #1;
    chk("validating", 48'h0, {47'h0, validating});
  endtask
  task automatic start(bit by_restart);
    @(posedge clock);
    if (by_restart) restart_req <= 1'b1;
    else io_write_command <= 1'b1;
    @(posedge clock);
    restart_req <= 1'b0;
    io_write_command <= 1'b0;
    wait_done();
  endtask
  task automatic fetch();
    @(posedge clock);
    fetch_next_fault_strobe <= 1'b1;
    @(posedge clock);
    fetch_next_fault_strobe <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic t_clean();
    chk("run", 48'h1, {47'h0, counting_enable});
    chk("words", 48'h0, io_word_area);
    fetch();
    chk("empty fetch", 48'h0, io_word_area);
    $display("clean done");
  endtask
  task automatic t_faults();
    put_clean();
    u_mem.mem_ff[2] = 16'h5000;
    u_mem.mem_ff[3] = 16'h6000;
    u_mem.mem_ff[4] = 16'h0200;
    u_mem.mem_ff[5] = 16'h0100;
    u_mem.mem_ff[7] = 16'h5500;
    u_mem.mem_ff[8] = 16'h0020;
    u_mem.mem_ff[12] = 16'h00a0;
    u_mem.mem_ff[18] = 16'h5000;
    u_mem.mem_ff[21] = 16'h0100;
    u_mem.mem_ff[23] = 16'h6000;
    u_mem.mem_ff[25] = 16'h0040;
    u_mem.mem_ff[27] = 16'h0050;
    start(1'b0);
    chk("halt", 48'h0, {47'h0, counting_enable});
    chk("last fault", {EXP[7], 16'h1}, io_word_area);
    // log entries in detection order, one per fetch
    fetch();
    chk("bcd entry", {EXP[0], 16'h1}, io_word_area);
    fetch();
    chk("init entry", {EXP[1], 16'h1}, io_word_area);
    fetch();
    chk("order entry", {EXP[2], 16'h1}, io_word_area);
    fetch();
    chk("range entry", {EXP[3], 16'h1}, io_word_area);
    fetch();
    chk("rate entry", {EXP[4], 16'h1}, io_word_area);
    fetch();
    chk("value entry", {EXP[5], 16'h1}, io_word_area);
    fetch();
    chk("equal entry", {EXP[6], 16'h1}, io_word_area);
    fetch();
    chk("overlap entry", {EXP[7], 16'h1}, io_word_area);
    fetch();
    chk("past end", 48'h1, io_word_area);
    fetch();
    chk("wrap", {EXP[0], 16'h1}, io_word_area);
    $display("faults done");
  endtask
  task automatic t_restart();
    put_clean();
    u_mem.mem_ff[16] = 16'h0003;
    start(1'b1);
    chk("mode fault", 48'h0300_0016_0001, io_word_area);
    put_clean();
    start(1'b1);
    chk("rerun", 48'h1, {47'h0, counting_enable});
    $display("restart done");
  endtask
  task automatic t_overflow();
    for (int i = 0; i < 32; i++) u_mem.mem_ff[i] = 16'haaaa;
    start(1'b0);
    for (int i = 0; i < 30; i++) begin
      fetch();
      chk("log", {16'h0310, 8'h0, 4'(i / 10), 4'(i % 10), 16'h1}, io_word_area);
    end
    fetch();
    chk("log end", 48'h1, io_word_area);
    $display("overflow done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(20000 * 50);
    fails++;
    end_of_test();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    io_write_command = 1'b0;
    restart_req = 1'b0;
    fetch_next_fault_strobe = 1'b0;
    put_clean();
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    wait_done();
    t_clean();
    t_faults();
    t_restart();
    t_overflow();
    end_of_test();
  end
endmodule // tb_cfv_validator
`default_nettype wire

// *** src/cfv_pkg.sv ***
// package: constants, layout and types of the configuration settings validator
// Operation
// - validate all settings after power-up or restart
// - revalidate on the reconfigure-unit command
// - on fault report, then halt counting
// - host fetches one logged fault per strobe, none if a new fault is reported in that cycle
// - out-of-range mode setting gives 0300 plus BCD offset
// - non-BCD nibble gives 0310 plus BCD offset
// - initial value outside counting range gives 0311
// - rate upper not above lower gives 0320
// - linear range upper below lower gives 0320
// - range mode limit outside counting range: 0330
// - comparison value outside counting range: 0330
// - equal comparison values give 0331
// - overlapping rate ranges give 0335
// - fault words shown, stored, any-fault bit set
// - log keeps up to thirty faults in order
// - strobe edge loads next unless a new fault comes in that cycle; past end zero, wraps
`default_nettype none
package cfv_pkg;
  localparam int WORD_W = 16;
  // fault codes for the first fault word
  localparam logic [15:0] CODE_RANGE   = 16'h0300;
  localparam logic [15:0] CODE_BCD     = 16'h0310;
  localparam logic [15:0] CODE_INIT    = 16'h0311;
  localparam logic [15:0] CODE_LIMITS  = 16'h0320;
  localparam logic [15:0] CODE_OUTSIDE = 16'h0330;
  localparam logic [15:0] CODE_EQUAL   = 16'h0331;
  localparam logic [15:0] CODE_OVERLAP = 16'h0335;
  // per-counter settings layout, word offsets within one counter block
  localparam int CNT_STRIDE = 16;
  localparam int OFS_MODE   = 0;
  localparam int OFS_MIN    = 1;
  localparam int OFS_MAX    = 2;
  localparam int OFS_INIT   = 3;
  localparam int OFS_LIM    = 4;   // four words: two range pairs or four comparison values
  localparam int NUM_LIM    = 4;
  localparam int OFS_RATE   = 8;   // two rate ranges, lower then upper
  localparam logic [15:0] MODE_MAX = 16'h0001;
  localparam int MODE_CMP_BIT = 0; // 1 = comparison mode, 0 = range mode
  localparam int STATUS_ANY_BIT = 0;
  localparam int LOG_DEPTH_DEF = 30;
  // check step numbers within one counter
  localparam logic [3:0] K_MODE  = 4'h0;
  localparam logic [3:0] K_INIT  = 4'h1;
  localparam logic [3:0] K_RNG0  = 4'h2;
  localparam logic [3:0] K_VAL0  = 4'h4;
  localparam logic [3:0] K_EQ0   = 4'h8;
  localparam logic [3:0] K_RATE0 = 4'hc;
  localparam logic [3:0] K_OVL   = 4'he;
  localparam logic [3:0] K_ONE   = 4'h1;
  localparam logic [7:0] C_ONE   = 8'h01;

  typedef enum logic [1:0] {
    ST_LOAD  = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN   = 2'b10,
    ST_HALT  = 2'b11
  } cfv_state_e;

  typedef struct packed {
    logic [15:0] code1;
    logic [15:0] code2;
  } cfv_fault_s;

  typedef struct packed {
    cfv_fault_s  fault;
    logic [15:0] status;
  } cfv_io_s;
endpackage
`default_nettype wire

// *** src/cfv_validator.sv ***
// module: configuration settings validator with fault log and host fault fetch
`timescale 1ns/100ps
`default_nettype none
module cfv_validator
  import cfv_pkg::*;
#(
  parameter int NCNT      = 2,
  parameter int LOG_DEPTH = LOG_DEPTH_DEF
) (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         resetn,
  // stored settings memory read port, one cycle latency
  output logic [$clog2(NCNT*CNT_STRIDE)-1:0] set_rd_addr,
  input  wire logic [WORD_W-1:0]            set_rd_data,
  // host commands
  input  wire logic                         io_write_command,
  input  wire logic                         restart_req,
  input  wire logic                         fetch_next_fault_strobe,
  // io word area and status
  output cfv_io_s                           io_word_area,
  output logic                              counting_enable,
  output logic                              validating
);
  localparam int NW = NCNT * CNT_STRIDE;
  localparam int AW = $clog2(NW);
  localparam logic [AW-1:0] A_LAST = AW'(NW - 1);
  localparam logic [7:0] C_LAST = 8'(NCNT - 1);
  localparam int PW = $clog2(LOG_DEPTH + 1);
  localparam logic [PW-1:0] P_FULL = PW'(LOG_DEPTH);
  localparam logic [PW-1:0] P_ONE = PW'(1);

  // small value to two BCD digits
  function automatic logic [7:0] to_bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction

  // value lies outside an inclusive counting range
  function automatic logic outside(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v < lo) || (v > hi);
  endfunction

  // any nibble above nine
  function automatic logic bad_bcd(input logic [15:0] v);
    return (v[3:0] > 4'h9) || (v[7:4] > 4'h9) || (v[11:8] > 4'h9) || (v[15:12] > 4'h9);
  endfunction

  cfv_state_e     state_ff, nxt_state;
  logic [AW-1:0]  addr_ff, nxt_addr;
  logic           ld_valid_ff, nxt_ld_valid;
  logic [AW-1:0]  ld_idx_ff, nxt_ld_idx;
  logic [7:0]     c_ff, nxt_c;
  logic [3:0]     k_ff, nxt_k;
  logic           fault_any_ff, nxt_fault_any;
  logic [15:0]    cfg_ff [NW];
  logic [15:0]    nxt_cfg [NW];
  cfv_fault_s     log_ff [LOG_DEPTH];
  cfv_fault_s     nxt_log [LOG_DEPTH];
  logic [PW-1:0]  log_cnt_ff, nxt_log_cnt;
  logic [PW-1:0]  rd_ptr_ff, nxt_rd_ptr;
  logic           strobe_d_ff, nxt_strobe_d;
  cfv_io_s        io_ff, nxt_io;
  logic           start;
  logic           push;
  cfv_fault_s     push_fault;
  logic           chk_hit;
  cfv_fault_s     chk_fault;

  assign start = io_write_command || restart_req;

  // evaluate the current check step of the current counter
  always_comb begin
    int base;
    int r;
    int j;
    logic [15:0] mode;
    logic [15:0] mn;
    logic [15:0] mx;
    logic cmp;
    logic [7:0] cnt;
    base = int'(c_ff) * CNT_STRIDE;
    r = 0;
    j = 0;
    mode = cfg_ff[base + OFS_MODE];
    mn = cfg_ff[base + OFS_MIN];
    mx = cfg_ff[base + OFS_MAX];
    cmp = mode[MODE_CMP_BIT];
    cnt = to_bcd(int'(c_ff) + 1);
    chk_hit = 1'b0;
    chk_fault = '0;
    if (k_ff == K_MODE) begin
      chk_hit = mode > MODE_MAX;
      chk_fault = {CODE_RANGE, 8'h00, to_bcd(base + OFS_MODE)};
    end else if (k_ff == K_INIT) begin
      chk_hit = outside(cfg_ff[base + OFS_INIT], mn, mx);
      chk_fault = {CODE_INIT, 8'h00, to_bcd(base + OFS_INIT)};
    end else if (k_ff < K_VAL0) begin
      r = int'(k_ff - K_RNG0);
      chk_hit = !cmp && (cfg_ff[base + OFS_LIM + 2 * r + 1] < cfg_ff[base + OFS_LIM + 2 * r]);
      chk_fault = {CODE_LIMITS, cnt, to_bcd(r + 1)};
    end else if (k_ff < K_EQ0) begin
      j = int'(k_ff - K_VAL0);
      if (cmp) begin
        chk_hit = outside(cfg_ff[base + OFS_LIM + j], mn, mx);
        chk_fault = {CODE_OUTSIDE, cnt, to_bcd(j + 1)};
      end else begin
        // one entry per range when either limit is outside
        chk_hit = (j % 2 == 0) && (outside(cfg_ff[base + OFS_LIM + j], mn, mx) ||
                  outside(cfg_ff[base + OFS_LIM + j + 1], mn, mx));
        chk_fault = {CODE_OUTSIDE, cnt, to_bcd(j / 2 + 1)};
      end
    end else if (k_ff < K_RATE0) begin
      j = int'(k_ff - K_EQ0);
      for (int m = 0; m < NUM_LIM; m++) begin
        if (m > j && cfg_ff[base + OFS_LIM + m] == cfg_ff[base + OFS_LIM + j]) begin
          chk_hit = cmp;
        end
      end
      chk_fault = {CODE_EQUAL, cnt, to_bcd(j + 1)};
    end else if (k_ff < K_OVL) begin
      r = int'(k_ff - K_RATE0);
      chk_hit = cfg_ff[base + OFS_RATE + 2 * r + 1] <= cfg_ff[base + OFS_RATE + 2 * r];
      chk_fault = {CODE_LIMITS, 8'h00, to_bcd(base + OFS_RATE + 2 * r)};
    end else if (k_ff == K_OVL) begin
      chk_hit = (cfg_ff[base + OFS_RATE + 2] <= cfg_ff[base + OFS_RATE + 1]) &&
                (cfg_ff[base + OFS_RATE] <= cfg_ff[base + OFS_RATE + 3]);
      chk_fault = {CODE_OVERLAP, 8'h00, to_bcd(base + OFS_RATE + 2)};
    end
  end

  // one fault source per cycle: bcd check while loading, else the check step
  always_comb begin
    push = 1'b0;
    push_fault = '0;
    if (!start && ld_valid_ff && bad_bcd(set_rd_data)) begin
      push = 1'b1;
      push_fault = {CODE_BCD, 8'h00, to_bcd(int'(ld_idx_ff))};
    end else if (!start && state_ff == ST_CHECK && chk_hit) begin
      push = 1'b1;
      push_fault = chk_fault;
    end
  end

  // sequencer next state: load all words, step checks, then run or halt
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_ld_valid = 1'b0;
    nxt_ld_idx = ld_idx_ff;
    nxt_c = c_ff;
    nxt_k = k_ff;
    nxt_fault_any = fault_any_ff || push;
    if (start) begin
      nxt_state = ST_LOAD;
      nxt_addr = '0;
      nxt_fault_any = 1'b0;
    end else begin
      unique case (state_ff)
        ST_LOAD: begin
          if (!(ld_valid_ff && ld_idx_ff == A_LAST)) begin
            nxt_ld_valid = 1'b1;
            nxt_ld_idx = addr_ff;
            if (addr_ff != A_LAST) begin
              nxt_addr = addr_ff + AW'(1);
            end
          end
          if (ld_valid_ff && ld_idx_ff == A_LAST) begin
            nxt_ld_valid = 1'b0;
            nxt_state = ST_CHECK;
            nxt_c = '0;
            nxt_k = K_MODE;
          end
        end
        ST_CHECK: begin
          if (k_ff == K_OVL) begin
            nxt_k = K_MODE;
            if (c_ff == C_LAST) begin
              nxt_state = (fault_any_ff || push) ? ST_HALT : ST_RUN;
            end else begin
              nxt_c = c_ff + C_ONE; // last counter keeps an in-range index
            end
          end else begin
            nxt_k = k_ff + K_ONE;
          end
        end
        ST_RUN: begin
        end
        ST_HALT: begin
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_LOAD;
      addr_ff <= '0;
      ld_valid_ff <= 1'b0;
      ld_idx_ff <= '0;
      c_ff <= '0;
      k_ff <= K_MODE;
      fault_any_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      ld_valid_ff <= nxt_ld_valid;
      ld_idx_ff <= nxt_ld_idx;
      c_ff <= nxt_c;
      k_ff <= nxt_k;
      fault_any_ff <= nxt_fault_any;
    end
  end

  // settings copy and fault log next values
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_log = log_ff;
    nxt_log_cnt = log_cnt_ff;
    if (ld_valid_ff && !start) begin
      nxt_cfg[ld_idx_ff] = set_rd_data;
    end
    if (start) begin
      nxt_log_cnt = '0;
    end else if (push && log_cnt_ff != P_FULL) begin
      nxt_log[log_cnt_ff] = push_fault;
      nxt_log_cnt = log_cnt_ff + P_ONE;
    end
  end

  // settings copy and fault log registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NW; i++) begin
        cfg_ff[i] <= '0;
      end
      for (int i = 0; i < LOG_DEPTH; i++) begin
        log_ff[i] <= '0;
      end
      log_cnt_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
      log_ff <= nxt_log;
      log_cnt_ff <= nxt_log_cnt;
    end
  end

  // host-visible fault words and fetch pointer
  always_comb begin
    nxt_io = io_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_strobe_d = fetch_next_fault_strobe;
    if (start) begin
      nxt_io = '0;
      nxt_rd_ptr = '0;
    end else if (push) begin
      nxt_io.fault = push_fault;
      nxt_io.status[STATUS_ANY_BIT] = 1'b1;
    end else if (fetch_next_fault_strobe && !strobe_d_ff) begin
      if (rd_ptr_ff < log_cnt_ff) begin
        nxt_io.fault = log_ff[rd_ptr_ff];
        nxt_rd_ptr = rd_ptr_ff + P_ONE;
      end else begin
        nxt_io.fault = '0;
        nxt_rd_ptr = '0;
      end
    end
  end

  // host-visible registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      io_ff <= '0;
      rd_ptr_ff <= '0;
      strobe_d_ff <= 1'b0;
    end else begin
      io_ff <= nxt_io;
      rd_ptr_ff <= nxt_rd_ptr;
      strobe_d_ff <= nxt_strobe_d;
    end
  end

  // outputs
  assign set_rd_addr     = addr_ff;
  assign io_word_area    = io_ff;
  assign counting_enable = (state_ff == ST_RUN);
  assign validating      = (state_ff == ST_LOAD) || (state_ff == ST_CHECK);
endmodule // cfv_validator
`default_nettype wire
